// *** afbc_pkg.sv ***
// Shared constants and types for the ALU flag and branch-condition block
package afbc_pkg;
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;
  localparam int SHAMT_W = 4;
  localparam int NIB_W = 4;
  localparam int LIT5_W = 5;
  localparam int SLIT4_W = 4;
  localparam int ACC_SAT_BIT = 31;
  // Branch taken costs one extra cycle
  localparam logic [1:0] BR_CYC_NT = 2'h1;
  localparam logic [1:0] BR_CYC_TK = 2'h2;
  localparam logic [39:0] ACC_ZERO = 40'h00_0000_0000;

  typedef enum logic [3:0] {
    AFBC_OP_NOP,
    AFBC_OP_ADD,
    AFBC_OP_SUM_WITH_CARRY_OP,
    AFBC_OP_ACC_ADD,
    AFBC_OP_ASR1,
    AFBC_OP_ASR_REG,
    AFBC_OP_ASR_LIT,
    AFBC_OP_BIT_CLR,
    AFBC_OP_BIT_SET,
    AFBC_OP_BIT_TGL,
    AFBC_OP_BIT_WR_C,
    AFBC_OP_BIT_WR_Z,
    AFBC_OP_BRANCH,
    AFBC_OP_BR_UNCOND,
    AFBC_OP_BR_COMPUTED
  } afbc_op_t;

  typedef enum logic [4:0] {
    AFBC_CC_C, AFBC_CC_GE, AFBC_CC_GEU, AFBC_CC_GT, AFBC_CC_GTU,
    AFBC_CC_LE, AFBC_CC_LEU, AFBC_CC_LT, AFBC_CC_LTU, AFBC_CC_N,
    AFBC_CC_NC, AFBC_CC_NN, AFBC_CC_NOV, AFBC_CC_NZ, AFBC_CC_OA,
    AFBC_CC_OB, AFBC_CC_OV, AFBC_CC_SA, AFBC_CC_SB, AFBC_CC_Z
  } afbc_cc_t;
endpackage

// *** afbc_shifter.sv ***
// Arithmetic right shifter with the flag terms it produces
`timescale 1ns/100ps
module afbc_shifter
  import afbc_pkg::*;
(
  // Operand
  input wire logic [DATA_W-1:0] opnd,
  input wire logic [SHAMT_W-1:0] shamt,
  // Result and flag terms
  output logic [DATA_W-1:0] res,
  output logic carry_out
);
  wire logic signed [DATA_W-1:0] opnd_s = signed'(opnd);
  // Single-step carry is the bit shifted out
  assign carry_out = opnd[0];
  assign res = DATA_W'(opnd_s >>> shamt);
endmodule // afbc_shifter

// *** afbc_cond.sv ***
// Branch condition evaluation from the status flags
`timescale 1ns/100ps
module afbc_cond
  import afbc_pkg::*;
(
  // Flags
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_ov,
  input wire logic flag_oa,
  input wire logic flag_ob,
  input wire logic flag_sa,
  input wire logic flag_sb,
  // Condition select and verdict
  input wire afbc_cc_t cc,
  output logic cond_true
);
  wire logic sgn_lt = flag_n ^ flag_ov;
  wire logic u_ge = flag_c;
  wire logic u_gt = flag_c & ~flag_z;
  wire logic s_ge = ~sgn_lt;
  wire logic s_gt = ~sgn_lt & ~flag_z;

  always_comb begin
    case (cc)
      AFBC_CC_C: cond_true = flag_c;
      AFBC_CC_GE: cond_true = s_ge;
      AFBC_CC_GEU: cond_true = u_ge;
      AFBC_CC_GT: cond_true = s_gt;
      AFBC_CC_GTU: cond_true = u_gt;
      AFBC_CC_LE: cond_true = ~s_gt;
      AFBC_CC_LEU: cond_true = ~u_gt;
      AFBC_CC_LT: cond_true = sgn_lt;
      AFBC_CC_LTU: cond_true = ~u_ge;
      AFBC_CC_N: cond_true = flag_n;
      AFBC_CC_NC: cond_true = ~flag_c;
      AFBC_CC_NN: cond_true = ~flag_n;
      AFBC_CC_NOV: cond_true = ~flag_ov;
      AFBC_CC_NZ: cond_true = ~flag_z;
      AFBC_CC_OA: cond_true = flag_oa;
      AFBC_CC_OB: cond_true = flag_ob;
      AFBC_CC_OV: cond_true = flag_ov;
      AFBC_CC_SA: cond_true = flag_sa;
      AFBC_CC_SB: cond_true = flag_sb;
      AFBC_CC_Z: cond_true = flag_z;
      default: cond_true = 1'b0;
    endcase
  end
endmodule // afbc_cond

// *** afbc_core.sv ***
// ALU datapath with status flags and branch timing
`timescale 1ns/100ps
module afbc_core
  import afbc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Instruction issue
  input wire logic op_valid,
  input wire afbc_op_t op_code,
  input wire afbc_cc_t op_cc,
  input wire logic [DATA_W-1:0] opnd_a,
  input wire logic [DATA_W-1:0] opnd_b,
  input wire logic [SHAMT_W-1:0] opnd_bit,
  input wire logic [SLIT4_W-1:0] opnd_slit4,
  input wire logic acc_sel,
  // Core stall
  output logic op_ready,
  // Result
  output logic res_valid,
  output logic [DATA_W-1:0] res_data,
  output logic br_taken,
  output logic [1:0] br_cycles,
  // Accumulators
  output logic [ACC_W-1:0] acc_a,
  output logic [ACC_W-1:0] acc_b,
  // Status flags
  output logic flag_c,
  output logic nibble_carry_flag,
  output logic flag_n,
  output logic signed_overflow_flag,
  output logic flag_z,
  output logic acc_a_overflow_flag,
  output logic acc_b_overflow_flag,
  output logic acc_a_saturation_flag,
  output logic acc_b_saturation_flag
);
  logic c_q, dc_q, n_q, ov_q, z_q, oa_q, ob_q, sa_q, sb_q;
  logic c_d, dc_d, n_d, ov_d, z_d, oa_d, ob_d, sa_d, sb_d;
  logic [ACC_W-1:0] acca_q, accb_q, acca_d, accb_d;
  logic ready_q;
  logic res_valid_q, br_taken_q;
  logic [1:0] br_cycles_q;
  logic [DATA_W-1:0] res_q;
  logic [DATA_W-1:0] res_d;

  wire logic issue = op_valid & ready_q;

  // Adder, one extra bit for carry out
  wire logic cin = (op_code == AFBC_OP_SUM_WITH_CARRY_OP) ? c_q : 1'b0;
  wire logic [DATA_W:0] sum = {1'b0, opnd_a} + {1'b0, opnd_b} + {{DATA_W{1'b0}}, cin};
  wire logic [NIB_W:0] nib_sum = {1'b0, opnd_a[NIB_W-1:0]} + {1'b0, opnd_b[NIB_W-1:0]}
                                 + {{NIB_W{1'b0}}, cin};
  wire logic add_ov = (opnd_a[DATA_W-1] == opnd_b[DATA_W-1]) &
                      (sum[DATA_W-1] != opnd_a[DATA_W-1]);

  // Shifter: single step uses count one
  wire logic is_asr1 = (op_code == AFBC_OP_ASR1);
  wire logic [SHAMT_W-1:0] shamt = is_asr1 ? SHAMT_W'(1) : opnd_b[SHAMT_W-1:0];
  wire logic [DATA_W-1:0] sh_res;
  wire logic sh_c;

  afbc_shifter u_shift (
    .opnd(opnd_a),
    .shamt(shamt),
    .res(sh_res),
    .carry_out(sh_c)
  );

  // Accumulator add: sign-extend, shift by signed literal
  wire logic signed [ACC_W-1:0] wext = ACC_W'(signed'(opnd_a));
  wire logic signed [SLIT4_W-1:0] slit = signed'(opnd_slit4);
  wire logic [SLIT4_W-1:0] slit_mag = slit[SLIT4_W-1] ? SLIT4_W'(-slit) : opnd_slit4;
  // Positive literal shifts right, negative shifts left
  wire logic [ACC_W-1:0] wsh = slit[SLIT4_W-1] ? (wext << slit_mag) : ACC_W'(wext >>> slit_mag);
  wire logic [ACC_W-1:0] acc_src = acc_sel ? accb_q : acca_q;
  wire logic [ACC_W:0] acc_sum = {1'b0, acc_src} + {1'b0, wsh};
  wire logic [ACC_W-1:0] acc_res = acc_sum[ACC_W-1:0];
  // Saturation when the 40-bit sum overflows; overflow into guard bits
  wire logic acc_sat = (acc_src[ACC_W-1] == wsh[ACC_W-1]) &
                       (acc_res[ACC_W-1] != acc_src[ACC_W-1]);
  wire logic acc_ovf = ~(&acc_res[ACC_W-1:ACC_SAT_BIT] | ~|acc_res[ACC_W-1:ACC_SAT_BIT]);

  wire logic cond_true;
  afbc_cond u_cond (
    .flag_c(c_q),
    .flag_z(z_q),
    .flag_n(n_q),
    .flag_ov(ov_q),
    .flag_oa(oa_q),
    .flag_ob(ob_q),
    .flag_sa(sa_q),
    .flag_sb(sb_q),
    .cc(op_cc),
    .cond_true(cond_true)
  );

  wire logic is_br = (op_code == AFBC_OP_BRANCH);
  wire logic is_br2 = (op_code == AFBC_OP_BR_UNCOND) | (op_code == AFBC_OP_BR_COMPUTED);
  wire logic take = (is_br & cond_true) | is_br2;
  wire logic [DATA_W-1:0] bit_mask = DATA_W'(1) << opnd_bit;

  always_comb begin
    c_d = c_q;
    dc_d = dc_q;
    n_d = n_q;
    ov_d = ov_q;
    z_d = z_q;
    oa_d = oa_q;
    ob_d = ob_q;
    sa_d = sa_q;
    sb_d = sb_q;
    acca_d = acca_q;
    accb_d = accb_q;
    res_d = res_q;
    if (issue) begin
      case (op_code)
        AFBC_OP_ADD, AFBC_OP_SUM_WITH_CARRY_OP: begin
          res_d = sum[DATA_W-1:0];
          c_d = sum[DATA_W];
          dc_d = nib_sum[NIB_W];
          n_d = sum[DATA_W-1];
          ov_d = add_ov;
          z_d = (sum[DATA_W-1:0] == '0);
        end
        AFBC_OP_ACC_ADD: begin
          // Only the accumulator flags move
          if (acc_sel) begin
            accb_d = acc_res;
            ob_d = acc_ovf;
            sb_d = sb_q | acc_sat;
          end else begin
            acca_d = acc_res;
            oa_d = acc_ovf;
            sa_d = sa_q | acc_sat;
          end
        end
        AFBC_OP_ASR_REG, AFBC_OP_ASR_LIT: begin
          res_d = sh_res;
          n_d = sh_res[DATA_W-1];
          z_d = (sh_res == '0);
        end
        AFBC_OP_ASR1: begin
          res_d = sh_res;
          c_d = sh_c;
          n_d = sh_res[DATA_W-1];
          ov_d = 1'b0; // Sign cannot change on arithmetic shift
          z_d = (sh_res == '0);
        end
        // Bit operations leave every flag alone
        AFBC_OP_BIT_CLR: res_d = opnd_a & ~bit_mask;
        AFBC_OP_BIT_SET: res_d = opnd_a | bit_mask;
        AFBC_OP_BIT_TGL: res_d = opnd_a ^ bit_mask;
        AFBC_OP_BIT_WR_C: res_d = c_q ? (opnd_a | bit_mask) : (opnd_a & ~bit_mask);
        AFBC_OP_BIT_WR_Z: res_d = z_q ? (opnd_a | bit_mask) : (opnd_a & ~bit_mask);
        default: res_d = res_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {c_q, dc_q, n_q, ov_q, z_q} <= 5'h00;
      {oa_q, ob_q, sa_q, sb_q} <= 4'h0;
      acca_q <= ACC_ZERO;
      accb_q <= ACC_ZERO;
      res_q <= '0;
    end else begin
      {c_q, dc_q, n_q, ov_q, z_q} <= {c_d, dc_d, n_d, ov_d, z_d};
      {oa_q, ob_q, sa_q, sb_q} <= {oa_d, ob_d, sa_d, sb_d};
      acca_q <= acca_d;
      accb_q <= accb_d;
      res_q <= res_d;
    end
  end

  // Taken branch holds issue for the flush cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ready_q <= 1'b1;
      res_valid_q <= 1'b0;
      br_taken_q <= 1'b0;
      br_cycles_q <= 2'h0;
    end else begin
      ready_q <= ~(issue & take);
      res_valid_q <= issue;
      br_taken_q <= issue & take;
      br_cycles_q <= !issue ? 2'h0 : (take ? BR_CYC_TK : BR_CYC_NT);
    end
  end

  assign op_ready = ready_q;
  assign res_valid = res_valid_q;
  assign res_data = res_q;
  assign br_taken = br_taken_q;
  assign br_cycles = br_cycles_q;
  assign acc_a = acca_q;
  assign acc_b = accb_q;
  assign flag_c = c_q;
  assign nibble_carry_flag = dc_q;
  assign flag_n = n_q;
  assign signed_overflow_flag = ov_q;
  assign flag_z = z_q;
  assign acc_a_overflow_flag = oa_q;
  assign acc_b_overflow_flag = ob_q;
  assign acc_a_saturation_flag = sa_q;
  assign acc_b_saturation_flag = sb_q;
endmodule // afbc_core

// *** afbc_core_props.sv ***
// Port checks for the ALU flag and branch block
`timescale 1ns/100ps
module afbc_core_props
  import afbc_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Issue
  input wire logic op_valid,
  input wire afbc_op_t op_code,
  input wire logic [DATA_W-1:0] opnd_a,
  input wire logic op_ready,
  // Result
  input wire logic res_valid,
  input wire logic [DATA_W-1:0] res_data,
  input wire logic br_taken,
  input wire logic [1:0] br_cycles,
  // Flags
  input wire logic flag_c,
  input wire logic nibble_carry_flag,
  input wire logic flag_n,
  input wire logic signed_overflow_flag,
  input wire logic flag_z
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire issue = op_valid && op_ready;
  wire lsb_a = opnd_a[0];
  wire [4:0] fl = {flag_c, nibble_carry_flag, flag_n, signed_overflow_flag, flag_z};
  wire arith = op_code inside {AFBC_OP_ADD, AFBC_OP_SUM_WITH_CARRY_OP, AFBC_OP_ASR1, AFBC_OP_ASR_LIT,
    AFBC_OP_ASR_REG};
  wire bit_op = op_code inside {[AFBC_OP_BIT_CLR:AFBC_OP_BIT_WR_Z]};
  wire asr_n = op_code inside {AFBC_OP_ASR_REG, AFBC_OP_ASR_LIT};
  wire uncond = op_code inside {AFBC_OP_BR_UNCOND, AFBC_OP_BR_COMPUTED};

  issue_answer_a: assert property (issue |=> res_valid)
    else $error("no result after issue");
  idle_quiet_a: assert property (!issue |=> !res_valid && br_cycles == 2'h0)
    else $error("result without issue");
  branch_cost_a: assert property (res_valid |->
    br_cycles == (br_taken ? BR_CYC_TK : BR_CYC_NT)) else $error("bad cycle count");
  taken_stall_a: assert property (res_valid && br_taken |-> !op_ready ##1 op_ready)
    else $error("bad stall after branch");
  uncond_taken_a: assert property (issue && uncond |=> br_taken)
    else $error("branch not taken");
  bit_flags_a: assert property (issue && bit_op |=> $stable(fl))
    else $error("bit op moved flags");
  shift_keep_a: assert property (issue && asr_n |=>
    $stable(flag_c) && $stable(signed_overflow_flag)) else $error("shift moved C or OV");
  shift_one_a: assert property (issue && op_code == AFBC_OP_ASR1 |=>
    flag_c == $past(lsb_a) && !signed_overflow_flag) else $error("single shift flags");
  neg_zero_a: assert property (issue && arith |=> flag_n == res_data[DATA_W-1] &&
    flag_z == (res_data == 16'h0000)) else $error("N or Z wrong");
  acc_keep_a: assert property (issue && op_code == AFBC_OP_ACC_ADD |=> $stable(fl))
    else $error("acc add moved flags");
endmodule // afbc_core_props

// *** testbench.sv ***
// Self-checking bench for the ALU flag and branch block
`timescale 1ns/100ps
module testbench;
  import afbc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  afbc_op_t op_code = AFBC_OP_NOP;
  afbc_cc_t op_cc = AFBC_CC_C;
  logic [15:0] opnd_a = 16'h0000;
  logic [15:0] opnd_b = 16'h0000;
  logic [3:0] opnd_bit = 4'h0;
  logic [3:0] opnd_slit4 = 4'h0;
  logic acc_sel = 1'b0;
  logic op_ready, res_valid, br_taken, flag_c, nibble_carry_flag, flag_n, flag_z;
  logic signed_overflow_flag, acc_a_overflow_flag, acc_b_overflow_flag;
  logic acc_a_saturation_flag, acc_b_saturation_flag;
  logic [15:0] res_data;
  logic [1:0] br_cycles;
  logic [39:0] acc_a, acc_b;
  logic mc = 1'b0, mdc = 1'b0, mn = 1'b0, mov = 1'b0, mz = 1'b0;
  logic moa = 1'b0, mob = 1'b0, msa = 1'b0, msb = 1'b0;
  logic [39:0] ma = 40'h00_0000_0000, mb = 40'h00_0000_0000;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #2.5 clk_sys = ~clk_sys;

  afbc_core uut (.clk_sys, .sys_rst, .op_valid, .op_code, .op_cc, .opnd_a, .opnd_b,
    .opnd_bit, .opnd_slit4, .acc_sel, .op_ready, .res_valid, .res_data, .br_taken,
    .br_cycles, .acc_a, .acc_b, .flag_c, .nibble_carry_flag, .flag_n,
    .signed_overflow_flag, .flag_z, .acc_a_overflow_flag, .acc_b_overflow_flag,
    .acc_a_saturation_flag, .acc_b_saturation_flag);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Condition table indexed by the condition code order
  function automatic logic cond_exp(afbc_cc_t cc);
    logic lt;
    logic [19:0] v;
    lt = mn ^ mov;
    v = {mz, msb, msa, mov, mob,
      moa, ~mz, ~mov, ~mn, ~mc, mn, ~mc, lt, ~mc | mz, lt | mz,
      mc & ~mz, ~mz & ~lt, mc, ~lt, mc};
    return v[cc];
  endfunction

  task automatic do_op(input afbc_op_t op, input afbc_cc_t cc, input logic [15:0] a, b);
    logic [16:0] s;
    logic [4:0] nb;
    logic [15:0] r;
    logic ci, tk, hr, sat, ovf;
    logic [39:0] w, sh, as, ar;
    logic [3:0] mag;
    while (op_ready !== 1'b1) @(posedge clk_sys) #1;
    opnd_bit = 4'($urandom);
    opnd_slit4 = 4'($urandom);
    acc_sel = 1'($urandom);
    ci = (op == AFBC_OP_SUM_WITH_CARRY_OP) ? mc : 1'b0;
    s = {1'b0, a} + {1'b0, b} + 17'(ci);
    nb = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
    tk = op inside {AFBC_OP_BR_UNCOND, AFBC_OP_BR_COMPUTED} ||
      (op == AFBC_OP_BRANCH && cond_exp(cc));
    hr = 1'b1;
    r = a;
    case (op)
      AFBC_OP_ADD, AFBC_OP_SUM_WITH_CARRY_OP: begin
        r = s[15:0];
        mc = s[16];
        mdc = nb[4];
        mov = (a[15] == b[15]) && (r[15] != a[15]);
      end
      AFBC_OP_ASR1: begin
        r = $signed(a) >>> 1;
        mc = a[0];
        mov = 1'b0;
      end
      AFBC_OP_ASR_REG, AFBC_OP_ASR_LIT: r = $signed(a) >>> b[3:0];
      AFBC_OP_ACC_ADD: begin
        // Negative literal shifts left, positive shifts right
        hr = 1'b0;
        w = 40'($signed(a));
        mag = opnd_slit4[3] ? 4'(-opnd_slit4) : opnd_slit4;
        sh = opnd_slit4[3] ? (w << mag) : 40'($signed(w) >>> mag);
        as = acc_sel ? mb : ma;
        ar = as + sh;
        sat = (as[39] == sh[39]) && (ar[39] != as[39]);
        ovf = !((&ar[39:31]) || !(|ar[39:31]));
        if (acc_sel) begin
          mb = ar;
          mob = ovf;
          msb = msb | sat;
        end else begin
          ma = ar;
          moa = ovf;
          msa = msa | sat;
        end
      end
      AFBC_OP_BIT_CLR: r[opnd_bit] = 1'b0;
      AFBC_OP_BIT_SET: r[opnd_bit] = 1'b1;
      AFBC_OP_BIT_TGL: r[opnd_bit] = ~a[opnd_bit];
      AFBC_OP_BIT_WR_C: r[opnd_bit] = mc;
      AFBC_OP_BIT_WR_Z: r[opnd_bit] = mz;
      default: hr = 1'b0;
    endcase
    if (op inside {[AFBC_OP_ADD:AFBC_OP_SUM_WITH_CARRY_OP], [AFBC_OP_ASR1:AFBC_OP_ASR_LIT]}) begin
      mn = r[15];
      mz = (r == 16'h0000);
    end
    op_code = op;
    op_cc = cc;
    opnd_a = a;
    opnd_b = b;
    op_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    check(16'(res_valid), 16'h0001, "strobe");
    check(16'(br_taken), 16'(tk), "verdict");
    check(16'(br_cycles), tk ? 16'h0002 : 16'h0001, "cycles");
    if (tk) check(16'(op_ready), 16'h0000, "stall");
    if (hr) check(res_data, r, "data");
    check(16'({flag_c, nibble_carry_flag, flag_n, signed_overflow_flag, flag_z}),
      16'({mc, mdc, mn, mov, mz}), "flags");
    check(16'({acc_a_overflow_flag, acc_b_overflow_flag, acc_a_saturation_flag,
      acc_b_saturation_flag}), 16'({moa, mob, msa, msb}), "acc flags");
    for (int k = 0; k < 3; k++) begin
      check(16'(acc_a >> (16 * k)), 16'(ma >> (16 * k)), "acc a");
      check(16'(acc_b >> (16 * k)), 16'(mb >> (16 * k)), "acc b");
    end
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    void'($urandom(51182));
    repeat (10) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    check(16'({op_ready, flag_c, flag_z, acc_a_saturation_flag}), 16'h0008, "reset");
    do_op(AFBC_OP_ADD, AFBC_CC_C, 16'hffff, 16'h0001);
    do_op(AFBC_OP_SUM_WITH_CARRY_OP, AFBC_CC_C, 16'h7fff, 16'h0000);
    do_op(AFBC_OP_BRANCH, AFBC_CC_OV, 16'h0000, 16'h0000);
    do_op(AFBC_OP_ASR_LIT, AFBC_CC_C, 16'h8000, 16'h000f);
    do_op(AFBC_OP_ASR_REG, AFBC_CC_C, 16'h4000, 16'h0010);
    do_op(AFBC_OP_ASR1, AFBC_CC_C, 16'h0001, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      do_op(AFBC_OP_BRANCH, afbc_cc_t'(i), 16'h0000, 16'h0000);
    end
    repeat (400) begin
      do_op(afbc_op_t'(1 + $urandom_range(13)), afbc_cc_t'($urandom_range(19)),
        16'($urandom), 16'($urandom));
    end
    op_valid = 1'b0;
    repeat (2) @(posedge clk_sys);
    summarize();
  end
endmodule // testbench

bind afbc_core afbc_core_props chk (.clk_sys, .sys_rst, .op_valid, .op_code, .opnd_a,
  .op_ready, .res_valid, .res_data, .br_taken, .br_cycles, .flag_c, .nibble_carry_flag,
  .flag_n, .signed_overflow_flag, .flag_z);
